/* File: clsq_defs.vh */
// Register offsets, field positions and reset values of the list sequencer.
`ifndef CLSQ_DEFS_VH
`define CLSQ_DEFS_VH
// ==========================================================
// Register byte offsets
`define CLSQ_A_CFG 12'h000
`define CLSQ_A_CTRL 12'h004
`define CLSQ_A_STAT 12'h008
`define CLSQ_A_CLPER 12'h00c
`define CLSQ_A_CVPER 12'h010
`define CLSQ_A_SETTLE 12'h014
`define CLSQ_A_TSTAMP 12'h018
`define CLSQ_A_SYNCSEL 12'h01c
`define CLSQ_A_LIST 12'h100
// ==========================================================
// Channel list entry fields
`define CLSQ_E_NEXT 31
`define CLSQ_E_DIR 30
`define CLSQ_E_SSHI 29
`define CLSQ_E_SSLO 28
`define CLSQ_E_IRQ 27
`define CLSQ_E_NOWAIT 26
`define CLSQ_E_SKIP 25
`define CLSQ_E_WAITCL 24
`define CLSQ_E_PULSE 23
`define CLSQ_E_WRITE 22
`define CLSQ_E_UPDALL 21
`define CLSQ_E_TSRQ 20
`define CLSQ_E_SLOW 19
`define CLSQ_E_DIFF 15
`define CLSQ_E_GAIN_HI 11
`define CLSQ_E_GAIN_LO 8
`define CLSQ_E_CHAN_HI 7
// ==========================================================
// Configuration word fields
`define CLSQ_C_TSCOPY 18
`define CLSQ_C_MAPPED 15
`define CLSQ_C_RECYCLE 13
`define CLSQ_C_TMREN 11
`define CLSQ_C_IRQEN 10
`define CLSQ_C_STOP_LO 8
`define CLSQ_C_START_LO 6
`define CLSQ_C_CV_LO 4
`define CLSQ_C_CL_LO 2
`define CLSQ_C_LAMP 1
`define CLSQ_C_EN 0
// Edge codes and clock source codes.
`define CLSQ_EDGE_SW 2'h0
`define CLSQ_EDGE_RISE 2'h1
`define CLSQ_EDGE_FALL 2'h2
`define CLSQ_SRC_SW 2'h1
`define CLSQ_SRC_HW 2'h2
`define CLSQ_SRC_EXT 2'h3
// Control register command bits.
`define CLSQ_K_START 0
`define CLSQ_K_STOP 1
`define CLSQ_K_CL 2
`define CLSQ_K_CV 3
// ==========================================================
// Reset values
`define CLSQ_R_CFG 32'h0000_0000
`define CLSQ_R_PER 32'h0000_03e8
`define CLSQ_R_SETTLE 16'h000a
`endif

/* File: clsq_sync_edge.v */
// Two-flop synchroniser with rise and fall detection per pin.
`timescale 1ns/1ps
module clsq_sync_edge #(
	parameter W = 4
) (
	input wire mclk, // System clock.
	input wire resetn, // Asynchronous reset, active low.
	input wire [W-1:0] din, // Pins from outside the clock domain.
	output wire [W-1:0] rise, // One-cycle pulse on a rising edge.
	output wire [W-1:0] fall // One-cycle pulse on a falling edge.
);
	// ==========================================================
	// Per-pin synchroniser
	genvar i;
	generate
		for (i = 0; i < W; i = i + 1) begin : g_pin
			reg s1_r;
			reg s2_r;
			reg s3_r;
			// The first stage feeds only the second stage.
			always @(posedge mclk or negedge resetn) begin
				if (!resetn) begin
					s1_r <= 1'b0;
					s2_r <= 1'b0;
					s3_r <= 1'b0;
				end else begin
					s1_r <= din[i];
					s2_r <= s1_r;
					s3_r <= s2_r;
				end
			end
			// Edges are taken between the second and third stage.
			assign rise[i] = s2_r & ~s3_r;
			assign fall[i] = ~s2_r & s3_r;
		end
	endgenerate
endmodule // clsq_sync_edge

/* File: clsq_seq.v */
// Channel list sequencer with its APB register file.
//
// Chosen here: the register offsets and register access over APB.
`timescale 1ns/1ps
`include "clsq_defs.vh"
module clsq_seq #(
	parameter DEPTH = 16, // Channel list entries.
	parameter NSYNC = 4 // Synchronisation lines.
) (
	input wire mclk, // 10 MHz system clock.
	input wire resetn, // Asynchronous reset, active low.
	input wire psel, // APB select.
	input wire penable, // APB enable.
	input wire pwrite, // APB write.
	input wire [11:0] paddr, // APB byte address.
	input wire [31:0] pwdata, // APB write data.
	output reg [31:0] prdata, // APB read data.
	output reg pready, // APB ready.
	output reg pslverr, // APB error on unmapped address.
	input wire ext_list_clock, // External list clock pin.
	input wire ext_conversion_clock, // External conversion clock pin.
	input wire start_trig_pin, // Start trigger pin.
	input wire stop_trig_pin, // Stop trigger pin.
	input wire conv_done, // Converter finished, one-cycle pulse.
	output reg [7:0] chan_r, // Current channel number.
	output reg [3:0] gain_r, // Current gain code.
	output reg [1:0] subsys_r, // Current subsystem.
	output reg diff_r, // Differential acquisition.
	output reg conv_start_r, // Start a conversion, pulse.
	output reg result_wr_r, // Push result to output FIFO, pulse.
	output reg in_pop_r, // Advance input FIFO pointer, pulse.
	output reg hold_load_r, // Load holding register, pulse.
	output reg update_all_r, // Apply all holding registers, pulse.
	output reg ts_valid_r, // Timestamp word valid, pulse.
	output reg [31:0] ts_word_r, // Timestamp word.
	output reg irq_r, // Interrupt to module processor, pulse.
	output reg [NSYNC-1:0] sync_line_r, // Sync line pulses.
	output reg status_lamp_r, // Status lamp.
	output reg [5:0] mode_flags_r // Cfg bits 15:10 for the layer.
);
	localparam AW = 12;
	localparam IW = $clog2(DEPTH);
	localparam S_IDLE = 6'h01;
	localparam S_SETTLE = 6'h02;
	localparam S_WAITCV = 6'h04;
	localparam S_CONV = 6'h08;
	localparam S_DONE = 6'h10;
	localparam S_WAITCL = 6'h20;
	reg [31:0] cfg_r;
	reg [31:0] clper_r;
	reg [31:0] cvper_r;
	reg [15:0] settle_r;
	reg [1:0] syncsel_r;
	reg [31:0] list_mem [0:DEPTH-1];
	reg [3:0] cmd_r;
	reg running_r;
	reg [5:0] state_r;
	reg [IW-1:0] ptr_r;
	reg [16:0] scnt_r;
	reg [31:0] clcnt_r;
	reg [31:0] cvcnt_r;
	reg [31:0] tstamp_r;
	reg nowait_r;
	reg [31:0] ent_r;
	wire [3:0] rise;
	wire [3:0] fall;
	// ==========================================================
	// Pin synchronisers
	clsq_sync_edge #(.W(4)) u_sync (
		.mclk(mclk),
		.resetn(resetn),
		.din({stop_trig_pin, start_trig_pin,
			ext_conversion_clock, ext_list_clock}),
		.rise(rise),
		.fall(fall)
	);
	// ==========================================================
	// Configuration decode
	wire en = cfg_r[`CLSQ_C_EN];
	wire [1:0] cl_src = cfg_r[`CLSQ_C_CL_LO+1:`CLSQ_C_CL_LO];
	wire [1:0] cv_src = cfg_r[`CLSQ_C_CV_LO+1:`CLSQ_C_CV_LO];
	wire [1:0] st_edge = cfg_r[`CLSQ_C_START_LO+1:`CLSQ_C_START_LO];
	wire [1:0] sp_edge = cfg_r[`CLSQ_C_STOP_LO+1:`CLSQ_C_STOP_LO];
	wire cl_tick = (clcnt_r == 32'h0);
	wire cv_tick = (cvcnt_r == 32'h0);

	// List clock event from the selected source.
	reg cl_ev;
	always @* begin
		case (cl_src)
		`CLSQ_SRC_SW: cl_ev = cmd_r[`CLSQ_K_CL];
		`CLSQ_SRC_HW: cl_ev = cl_tick;
		`CLSQ_SRC_EXT: cl_ev = rise[0];
		default: cl_ev = 1'b0;
		endcase
	end
	// Conversion clock event from the selected source.
	reg cv_ev;
	always @* begin
		case (cv_src)
		`CLSQ_SRC_SW: cv_ev = cmd_r[`CLSQ_K_CV];
		`CLSQ_SRC_HW: cv_ev = cv_tick;
		`CLSQ_SRC_EXT: cv_ev = rise[1];
		default: cv_ev = 1'b0;
		endcase
	end
	// Start and stop trigger from the selected edge.
	reg start_ev;
	reg stop_ev;
	always @* begin
		case (st_edge)
		`CLSQ_EDGE_SW: start_ev = cmd_r[`CLSQ_K_START];
		`CLSQ_EDGE_RISE: start_ev = rise[2];
		`CLSQ_EDGE_FALL: start_ev = fall[2];
		default: start_ev = 1'b0;
		endcase
		case (sp_edge)
		`CLSQ_EDGE_SW: stop_ev = cmd_r[`CLSQ_K_STOP];
		`CLSQ_EDGE_RISE: stop_ev = rise[3];
		`CLSQ_EDGE_FALL: stop_ev = fall[3];
		default: stop_ev = 1'b0;
		endcase
	end
	// ==========================================================
	// APB slave, one wait state on every access
	wire acc = psel & penable & ~pready;
	wire in_list = (paddr >= `CLSQ_A_LIST) &&
		(paddr < `CLSQ_A_LIST + DEPTH * 4);
	wire [AW-1:0] loff = paddr - `CLSQ_A_LIST;
	wire [IW-1:0] lidx = loff[IW+1:2];
	reg hit;
	reg [31:0] rd;
	always @* begin
		hit = 1'b1;
		rd = 32'h0;
		case (paddr)
		`CLSQ_A_CFG: rd = cfg_r;
		`CLSQ_A_CTRL: rd = 32'h0;
		`CLSQ_A_STAT: rd = {16'h0, {(8-IW){1'b0}}, ptr_r,
			state_r, en, running_r};
		`CLSQ_A_CLPER: rd = clper_r;
		`CLSQ_A_CVPER: rd = cvper_r;
		`CLSQ_A_SETTLE: rd = {16'h0, settle_r};
		`CLSQ_A_TSTAMP: rd = tstamp_r;
		`CLSQ_A_SYNCSEL: rd = {30'h0, syncsel_r};
		default: begin
			hit = in_list;
			rd = in_list ? list_mem[lidx] : 32'h0;
		end
		endcase
	end
	// Bus answer and register writes.
	always @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h0;
			cfg_r <= `CLSQ_R_CFG;
			clper_r <= `CLSQ_R_PER;
			cvper_r <= `CLSQ_R_PER;
			settle_r <= `CLSQ_R_SETTLE;
			syncsel_r <= 2'h0;
			cmd_r <= 4'h0;
		end else begin
			pready <= acc;
			pslverr <= acc & ~hit;
			prdata <= (acc & ~pwrite) ? rd : 32'h0;
			cmd_r <= 4'h0;
			if (acc & pwrite) begin
				case (paddr)
				`CLSQ_A_CFG: cfg_r <= pwdata;
				`CLSQ_A_CTRL: cmd_r <= pwdata[3:0];
				`CLSQ_A_CLPER: clper_r <= pwdata;
				`CLSQ_A_CVPER: cvper_r <= pwdata;
				`CLSQ_A_SETTLE: settle_r <= pwdata[15:0];
				`CLSQ_A_SYNCSEL: syncsel_r <= pwdata[1:0];
				default: ;
				endcase
			end
		end
	end
	// List memory written by software; no reset needed on contents.
	always @(posedge mclk) begin
		if (acc & pwrite & in_list)
			list_mem[lidx] <= pwdata;
	end
	// ==========================================================
	// Internal clock timers and timestamp counter
	always @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			clcnt_r <= `CLSQ_R_PER;
			cvcnt_r <= `CLSQ_R_PER;
			tstamp_r <= 32'h0;
		end else begin
			tstamp_r <= tstamp_r + 32'h1;
			// Period counters reload so ticks come equally spaced.
			clcnt_r <= cl_tick ? clper_r : clcnt_r - 32'h1;
			cvcnt_r <= cv_tick ? cvper_r : cvcnt_r - 32'h1;
		end
	end

	// ==========================================================
	// Run control: start and stop triggers, gated by layer enable
	always @(posedge mclk or negedge resetn) begin
		if (!resetn)
			running_r <= 1'b0;
		else if (!en || stop_ev)
			running_r <= 1'b0;
		else if (start_ev)
			running_r <= 1'b1;
	end

	// ==========================================================
	// Sequencer state machine
	wire [31:0] cur = list_mem[ptr_r];
	wire last = ~ent_r[`CLSQ_E_NEXT];
	wire use_cv = (cv_src != 2'h0);
	wire [16:0] settle_ld = ent_r[`CLSQ_E_SLOW] ?
		{settle_r, 1'b0} : {1'b0, settle_r};
	wire [IW-1:0] ptr_inc = ptr_r + {{(IW-1){1'b0}}, 1'b1};

	always @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			state_r <= S_IDLE;
			ptr_r <= {IW{1'b0}};
			scnt_r <= 17'h0;
			nowait_r <= 1'b0;
			ent_r <= 32'h0;
			chan_r <= 8'h0;
			gain_r <= 4'h0;
			subsys_r <= 2'h0;
			diff_r <= 1'b0;
			conv_start_r <= 1'b0;
			result_wr_r <= 1'b0;
			in_pop_r <= 1'b0;
			hold_load_r <= 1'b0;
			update_all_r <= 1'b0;
			ts_valid_r <= 1'b0;
			ts_word_r <= 32'h0;
			irq_r <= 1'b0;
			sync_line_r <= {NSYNC{1'b0}};
		end else begin
			conv_start_r <= 1'b0;
			result_wr_r <= 1'b0;
			in_pop_r <= 1'b0;
			hold_load_r <= 1'b0;
			update_all_r <= 1'b0;
			ts_valid_r <= 1'b0;
			irq_r <= 1'b0;
			sync_line_r <= {NSYNC{1'b0}};
			case (state_r)
			S_IDLE: begin
				ptr_r <= {IW{1'b0}};
				nowait_r <= 1'b0;
				// One list clock starts the list; after an entry with the WAITCL bit the next entry waits for another.
				if (running_r && cl_ev) begin
					ent_r <= cur;
					state_r <= S_SETTLE;
					scnt_r <= 17'h0;
				end
			end
			S_SETTLE: begin
				// Present the channel, then let it settle.
				chan_r <= ent_r[`CLSQ_E_CHAN_HI:0];
				gain_r <= ent_r[`CLSQ_E_GAIN_HI:`CLSQ_E_GAIN_LO];
				subsys_r <= {ent_r[`CLSQ_E_SSHI],
					ent_r[`CLSQ_E_SSLO]};
				diff_r <= ent_r[`CLSQ_E_DIFF];
				if (scnt_r + 17'h1 >= settle_ld) begin
					if (use_cv && !nowait_r)
						state_r <= S_WAITCV;
					else
						state_r <= S_CONV;
				end else
					scnt_r <= scnt_r + 17'h1;
			end
			S_WAITCV: begin
				if (cv_ev)
					state_r <= S_CONV;
			end
			S_CONV: begin
				conv_start_r <= 1'b1;
				state_r <= S_DONE;
			end
			S_DONE: begin
				if (conv_done) begin
					// Skipped entries convert but neither push a result nor pop the input; hold, update, irq and sync pulses still fire.
					if (!ent_r[`CLSQ_E_SKIP]) begin
						result_wr_r <= ~ent_r[`CLSQ_E_DIR];
						in_pop_r <= ent_r[`CLSQ_E_DIR];
					end
					irq_r <= ent_r[`CLSQ_E_IRQ] &
						cfg_r[`CLSQ_C_IRQEN];
					if (ent_r[`CLSQ_E_PULSE])
						sync_line_r <= {{(NSYNC-1){1'b0}}, 1'b1}
							<< syncsel_r;
					hold_load_r <= ent_r[`CLSQ_E_WRITE];
					update_all_r <= ent_r[`CLSQ_E_UPDALL];
					// Timestamp per entry or at the end of the list.
					ts_valid_r <= ent_r[`CLSQ_E_TSRQ] | (last &
						cfg_r[`CLSQ_C_TSCOPY]);
					ts_word_r <= tstamp_r;
					nowait_r <= ent_r[`CLSQ_E_NOWAIT];
					scnt_r <= 17'h0;
					if (last || ptr_inc == {IW{1'b0}}) begin
						ptr_r <= {IW{1'b0}};
						state_r <= S_IDLE;
					end else begin
						ptr_r <= ptr_inc;
						state_r <= ent_r[`CLSQ_E_WAITCL] ?
							S_WAITCL : S_SETTLE;
					end
				end
			end
			S_WAITCL: begin
				ent_r <= cur;
				if (cl_ev)
					state_r <= S_SETTLE;
			end
			default: state_r <= S_IDLE;
			endcase
			if (state_r == S_DONE && conv_done && !last &&
				ptr_inc != {IW{1'b0}})
				ent_r <= list_mem[ptr_inc];
			// Leaving enable or a stop trigger aborts the list.
			if (!running_r && state_r != S_IDLE)
				state_r <= S_IDLE;
		end
	end

	// ==========================================================
	// Registered configuration outputs
	always @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			status_lamp_r <= 1'b0;
			mode_flags_r <= 6'h0;
		end else begin
			status_lamp_r <= cfg_r[`CLSQ_C_LAMP];
			mode_flags_r <= cfg_r[`CLSQ_C_MAPPED:`CLSQ_C_IRQEN];
		end
	end
endmodule // clsq_seq

/* File: clsq_conv_model.sv */
// Behavioural converter that answers each start with a done pulse.
`timescale 1ns/1ps
module clsq_conv_model (
	input wire mclk, // System clock.
	input wire resetn, // Reset, active low.
	input wire conv_start, // Conversion request pulse.
	input wire [3:0] lat, // Idle cycles from start to done.
	output reg conv_done // One-cycle completion pulse.
);
	reg [3:0] cnt_r;
	reg busy_r;
	// ==========================================================
	// Converter timing
	// Wait the set latency after a start, then pulse done once.
	always @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			cnt_r <= 4'h0;
			busy_r <= 1'b0;
			conv_done <= 1'b0;
		end else begin
			conv_done <= 1'b0;
			if (conv_start) begin
				busy_r <= 1'b1;
				cnt_r <= lat;
			end else if (busy_r && cnt_r == 4'h0) begin
				busy_r <= 1'b0;
				conv_done <= 1'b1;
			end else if (busy_r) begin
				cnt_r <= cnt_r - 4'h1;
			end
		end
	end
endmodule // clsq_conv_model

/* File: clsq_seq_assertions.sv */
// Port-level assertions for the list sequencer.
`timescale 1ns/1ps
module clsq_seq_chk #(
	parameter DEPTH = 16,
	parameter NSYNC = 4
) (
	input wire mclk, // System clock.
	input wire resetn, // Reset, active low.
	input wire psel, // APB select.
	input wire penable, // APB enable.
	input wire [31:0] prdata, // APB read data.
	input wire pready, // APB ready.
	input wire pslverr, // APB error.
	input wire conv_done, // Converter done.
	input wire [7:0] chan_r, // Channel.
	input wire [3:0] gain_r, // Gain.
	input wire diff_r, // Differential.
	input wire conv_start_r, // Conversion start.
	input wire result_wr_r, // Result push.
	input wire in_pop_r, // Input pop.
	input wire hold_load_r, // Holding load.
	input wire update_all_r, // Update all.
	input wire irq_r, // Interrupt.
	input wire [NSYNC-1:0] sync_line_r // Sync pulses.
);
	// ==========================================================
	// Checks
	default clocking @(posedge mclk); endclocking
	default disable iff (!resetn);
	sequence apb_take;
		psel && penable && !pready;
	endsequence
	sequence ready_once;
		pready ##1 !pready;
	endsequence
	// Any per-entry action pulse other than the conversion start and the timestamp valid.
	wire acts = result_wr_r | in_pop_r | hold_load_r | update_all_r |
		irq_r | (|sync_line_r);
	apb_wait_a: assert property (apb_take |=> ready_once)
		else $error("ready not one cycle after take");
	slverr_ready_a: assert property (pslverr |-> pready)
		else $error("error without ready");
	rdata_idle_a: assert property (!pready |-> prdata == 32'h0)
		else $error("read data outside ready");
	action_cause_a: assert property (acts |-> $past(conv_done))
		else $error("action pulse without done");
	dir_excl_a: assert property (result_wr_r |-> !in_pop_r)
		else $error("push and pop together");
	sync_once_a: assert property ((|sync_line_r) |->
		$onehot(sync_line_r) ##1 (sync_line_r == 0))
		else $error("sync pulse not single");
	start_gap_a: assert property (conv_start_r |=> !conv_start_r [*2])
		else $error("starts too close");
	chan_hold_a: assert property (conv_start_r |->
		$stable(chan_r) && $stable(gain_r) && $stable(diff_r))
		else $error("channel fields move at start");
endmodule // clsq_seq_chk
bind clsq_seq clsq_seq_chk #(.DEPTH(DEPTH), .NSYNC(NSYNC)) i_chk (
	.mclk, .resetn, .psel, .penable, .prdata, .pready, .pslverr,
	.conv_done, .chan_r, .gain_r, .diff_r, .conv_start_r, .result_wr_r,
	.in_pop_r, .hold_load_r, .update_all_r, .irq_r, .sync_line_r);

/* File: tb_channel_list_sequencer.sv */
// Self-checking bench for the channel list sequencer.
`timescale 1ns/1ps
`include "clsq_defs.vh"
module tb_channel_list_sequencer;
	reg mclk, resetn, psel, penable, pwrite, ecl, strt, err, stp, ecv;
	reg [11:0] paddr;
	reg [31:0] pwdata, rd, ts_prev, ts_last;
	reg [3:0] lat, last_sync;
	reg [15:0] chans [0:15];
	reg [31:0] ents [0:3];
	wire [31:0] prdata, ts_word;
	wire pready, pslverr, done, cs, rw, ip, hl, ua, tv, irq, diff, lamp;
	wire [7:0] chan;
	wire [3:0] gain, sync;
	wire [1:0] ss;
	wire [5:0] mode;
	integer fails, compares, i, n_cs, n_rw, n_ip, n_hl, n_ua, n_tv, n_irq;
	// ==========================================================
	// Design and converter
	clsq_seq #(.DEPTH(16), .NSYNC(4)) i_dut (.mclk, .resetn, .psel,
		.penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
		.ext_list_clock(ecl), .ext_conversion_clock(ecv),
		.start_trig_pin(strt), .stop_trig_pin(stp), .conv_done(done),
		.chan_r(chan), .gain_r(gain), .subsys_r(ss), .diff_r(diff),
		.conv_start_r(cs), .result_wr_r(rw), .in_pop_r(ip),
		.hold_load_r(hl), .update_all_r(ua), .ts_valid_r(tv),
		.ts_word_r(ts_word), .irq_r(irq), .sync_line_r(sync),
		.status_lamp_r(lamp), .mode_flags_r(mode));
	clsq_conv_model i_conv (.mclk(mclk), .resetn(resetn),
		.conv_start(cs), .lat(lat), .conv_done(done));
	// Clock of 100 ns period.
	initial begin
		mclk = 1'b0;
		forever #50 mclk = ~mclk;
	end
	// Tally pulses at the falling edge, where outputs are settled.
	always @(negedge mclk) begin
		if (cs === 1'b1) begin
			chans[n_cs[3:0]] = {3'h0, diff, gain, chan};
			n_cs = n_cs + 1;
		end
		if (sync !== 4'h0)
			last_sync = sync;
		if (tv === 1'b1) begin
			ts_prev = ts_last;
			ts_last = ts_word;
		end
		n_rw = n_rw + rw;
		n_ip = n_ip + ip;
		n_hl = n_hl + hl;
		n_ua = n_ua + ua;
		n_tv = n_tv + tv;
		n_irq = n_irq + irq;
	end
	// ==========================================================
	// Tasks
	task apb(input w, input [11:0] a, input [31:0] d);
		integer t;
		begin
			t = 0;
			psel <= 1'b1;
			pwrite <= w;
			paddr <= a;
			pwdata <= d;
			@(posedge mclk);
			penable <= 1'b1;
			@(posedge mclk);
			while (pready !== 1'b1 && t < 50) begin
				t = t + 1;
				@(posedge mclk);
			end
			if (t == 50)
				fails = fails + 1;
			rd = prdata;
			err = pslverr;
			psel <= 1'b0;
			penable <= 1'b0;
			@(posedge mclk);
		end
	endtask
	task chk(input [31:0] got, input [31:0] exp);
		begin
			compares = compares + 1;
			if (got !== exp) begin
				fails = fails + 1;
				$display("mismatch at %0t got %h exp %h", $time, got, exp);
			end
		end
	endtask
	task rd_chk(input [11:0] a, input [31:0] exp);
		begin
			apb(1'b0, a, 32'h0);
			chk(rd, exp);
		end
	endtask
	// Wait until n starts are seen or the limit runs out, then settle.
	task wait_cs(input integer n, input integer lim);
		integer t;
		begin
			t = 0;
			while (n_cs < n && t < lim) begin
				t = t + 1;
				@(posedge mclk);
			end
			repeat (40) @(posedge mclk);
		end
	endtask
	task finish_test;
		begin
			$display("compares %0d fails %0d", compares, fails);
			if (fails == 0 && compares > 0)
				$display("All tests passed");
			else
				$display("Some tests failed");
			$finish;
		end
	endtask
	// Cut a hang short.
	initial begin
		#2000000;
		fails = fails + 1;
		finish_test;
	end
	// ==========================================================
	// Scenarios
	initial begin
		{resetn, psel, penable, pwrite, ecl, strt, err, stp, ecv} = 9'h0;
		{paddr, pwdata, rd, last_sync, ts_prev, ts_last} = 0;
		{fails, compares, n_cs, n_rw, n_ip, n_hl, n_ua, n_tv, n_irq} = 0;
		lat = 4'h1;
		ents[0] = 32'h8c00_8312;
		ents[1] = 32'h8240_0021;
		ents[2] = 32'hb1f0_0034;
		ents[3] = 32'h1008_00ff;
		repeat (2) @(posedge mclk);
		resetn <= 1'b1;
		@(posedge mclk);
		rd_chk(`CLSQ_A_CFG, `CLSQ_R_CFG);
		rd_chk(`CLSQ_A_CLPER, `CLSQ_R_PER);
		rd_chk(`CLSQ_A_SETTLE, {16'h0, `CLSQ_R_SETTLE});
		apb(1'b0, 12'h0f0, 32'h0);
		chk({31'h0, err}, 32'h1);
		apb(1'b1, `CLSQ_A_CFG, 32'h0004_fc02);
		rd_chk(`CLSQ_A_CFG, 32'h0004_fc02);
		chk({26'h0, mode}, 32'h3f);
		chk({31'h0, lamp}, 32'h1);
		$display("test registers done");
		// Firmware marks outputs deferred and applies them together.
		for (i = 0; i < 4; i = i + 1)
			apb(1'b1, `CLSQ_A_LIST + {i[9:0], 2'b00}, ents[i]);
		apb(1'b1, `CLSQ_A_SETTLE, 32'h2);
		apb(1'b1, `CLSQ_A_SYNCSEL, 32'h2);
		apb(1'b1, `CLSQ_A_CFG, 32'h0405);
		apb(1'b1, `CLSQ_A_CTRL, 32'h1);
		apb(1'b1, `CLSQ_A_CTRL, 32'h4);
		wait_cs(4, 300);
		chk({31'h0, n_cs < 4}, 32'h1);
		apb(1'b1, `CLSQ_A_CTRL, 32'h4);
		wait_cs(5, 300);
		chk(n_cs, 32'h4);
		chk(chans[0], 32'h1312);
		chk(chans[3], 32'hff);
		chk({22'h0, ss, chan}, 32'h1ff);
		chk(n_rw, 32'h3);
		chk(n_ip, 32'h0);
		chk(n_hl, 32'h2);
		chk(n_ua, 32'h1);
		chk(n_tv, 32'h1);
		chk(n_irq, 32'h1);
		chk({28'h0, last_sync}, 32'h4);
		$display("test list run done");
		lat <= 4'h6;
		apb(1'b1, `CLSQ_A_CFG, 32'h0415);
		apb(1'b1, `CLSQ_A_CTRL, 32'h4);
		wait_cs(5, 300);
		chk(n_cs, 32'h4);
		apb(1'b1, `CLSQ_A_CTRL, 32'h8);
		wait_cs(7, 300);
		chk(n_cs, 32'h6);
		chk(chans[4], 32'h1312);
		chk(chans[5], 32'h21);
		$display("test conversion clock done");
		apb(1'b1, `CLSQ_A_CTRL, 32'h2);
		apb(1'b1, `CLSQ_A_CFG, 32'h044d);
		strt <= 1'b1;
		repeat (6) @(posedge mclk);
		ecl <= 1'b1;
		repeat (6) @(posedge mclk);
		ecl <= 1'b0;
		wait_cs(7, 300);
		chk({31'h0, n_cs > 6}, 32'h1);
		$display("test external clock done");
		// A falling stop pin halts the list and leaves the sequencer idle.
		apb(1'b1, `CLSQ_A_CFG, 32'h064d);
		stp <= 1'b1;
		repeat (6) @(posedge mclk);
		stp <= 1'b0;
		repeat (6) @(posedge mclk);
		rd_chk(`CLSQ_A_STAT, 32'h6);
		// One input entry timed by the hardware list timer and the pin.
		apb(1'b1, `CLSQ_A_LIST, 32'h4000_0005);
		apb(1'b1, `CLSQ_A_CLPER, 32'h3f);
		rd_chk(`CLSQ_A_CLPER, 32'h3f);
		apb(1'b1, `CLSQ_A_CFG, 32'h0004_0639);
		apb(1'b1, `CLSQ_A_CTRL, 32'h1);
		repeat (1100) @(posedge mclk);
		chk(n_cs, 32'h9);
		ecv <= 1'b1;
		wait_cs(10, 300);
		chk(n_cs, 32'ha);
		chk(chans[9], 32'h5);
		chk(n_ip, 32'h1);
		chk(n_tv, 32'h3);
		chk({31'h0, ts_last > ts_prev}, 32'h1);
		$display("test hardware clock done");
		finish_test;
	end
endmodule // tb_channel_list_sequencer
